//--- shared/pciarb_regs.vh
// Purpose: constants for the PCI arbiter and strap pin-function block
// Assumes: 100 MHz clock, plain register port
// Notes: all offsets are word indices on the register port
`ifndef PCIARB_REGS_VH
`define PCIARB_REGS_VH
`define PCIARB_ADDR_W 4
`define PCIARB_OFF_CTRL 4'h0
`define PCIARB_OFF_STATUS 4'h1
`define PCIARB_OFF_ROUTE 4'h2
`define PCIARB_OFF_GRANT 4'h3
`define PCIARB_CTRL_SERR_EN 0
`define PCIARB_CTRL_FLUSH_REQ 1
`define PCIARB_CTRL_ISA_REQ 2
`define PCIARB_CTRL_IDE_REQ 3
`define PCIARB_CTRL_NMI_CLR 4
`define PCIARB_ST_ARB_EN 0
`define PCIARB_ST_FLUSH_MODE 1
`define PCIARB_ST_CPU_ALT 2
`define PCIARB_ST_NMI 3
`define PCIARB_ST_LOCKED 4
`define PCIARB_ST_FLUSH_ACK 5
`define PCIARB_ST_STRAP_DONE 6
`define PCIARB_CTRL_RESET 8'h00
`define PCIARB_ROUTE_RESET 16'h0000
`define PCIARB_NREQ 7
`define PCIARB_STRAP_WAIT 4'h4
`endif

//--- core/pciarb_sync.v
// Purpose: two-flop level synchroniser for asynchronous pins
// Assumes: destination clock is the PCI clock
// Notes: first stage feeds only the second
module pciarb_sync (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Data
  input wire d_in,
  output wire q_out
);
  reg meta_reg;
  reg sync_reg;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end
  assign q_out = sync_reg;
endmodule

//--- core/pciarb_top.v
// Purpose: PCI arbiter, strap capture, pin-function muxing, NMI, IRQ routing, lock
// Assumes: request, grant, error, interrupt and lock pins active low as on the PCI bus; PCI clock at 100 MHz
// Notes: strapped pins stay undriven until strap capture completes
//
// Added by the designer: the address map and strobed register access.
`include "pciarb_regs.vh"

// Contract
// - Arbiter off: ISA request out; on: grant 0
// - Arbiter off: grant to ISA; on: request 0
// - Arbiter off: IDE request out; on: grant 1
// - Arbiter off: grant to IDE; on: request 1
// - Low arbiter strap disables; else grant 2
// - Request 2 considered when arbiter enabled
// - Request/grant 3 ordinary pair when enabled
// - Fifth strap low with arbiter on: pair 4; else flush
// - Sample cpu family strap after power good
// - Enabled arbiter: family pin grants host bridge
// - Host bridge request accepted when enabled
// - System error with enable raises NMI
// - Software routes four PCI interrupts to PIC
// - Lock held until atomic operation completes
module pciarb_top (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  input wire power_good_in,
  // Register port
  input wire [3:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [15:0] reg_rdata_out,
  // Pin 26/25 and 28/27 pairs
  output reg isa_req_gnt0_n_out,
  input wire isa_gnt_req0_n_in,
  output reg ide_req_gnt1_n_out,
  input wire ide_gnt_req1_n_in,
  // Arbiter-disable strap / grant 2
  input wire arb_strap_gnt2_n_in,
  output reg arb_strap_gnt2_n_out,
  output reg arb_strap_gnt2_oe_out,
  input wire req2_n_in,
  // Fifth-master strap / grant 3
  input wire fifth_master_strap_gnt3_n_in,
  output reg fifth_master_strap_gnt3_n_out,
  output reg fifth_master_strap_gnt3_oe_out,
  input wire req3_n_in,
  // Grant 4 / flush request, request 4 / flush ack
  output reg gnt4_buffer_flush_request_n_out,
  input wire req4_buffer_flush_ack_n_in,
  // Cpu family strap / host bridge grant
  input wire cpu_family_strap_in,
  output reg host_bridge_grant_n_out,
  output reg host_bridge_grant_oe_out,
  input wire host_bridge_request_n_in,
  // Error, interrupts, lock
  input wire serr_n_in,
  input wire [3:0] pci_int_n_in,
  input wire lock_n_in,
  output reg nmi_out,
  output reg [15:0] pic_irq_out,
  output reg lock_active_out,
  output reg cpu_alt_mode_out
);
  // ****************************************************
  // Strap capture
  // ****************************************************
  localparam ST_WAIT = 3'b001;
  localparam ST_SAMPLE = 3'b010;
  localparam ST_RUN = 3'b100;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [3:0] wait_reg;
  reg arb_en_reg;
  reg flush_mode_reg;
  reg cpu_alt_reg;
  reg pg_d_reg;
  // Inverted so the synchroniser's reset level reads as power not good
  wire pg_n_s;
  wire pg_s = ~pg_n_s;
  wire serr_s;
  wire lock_s;
  wire [3:0] int_s;
  wire strap_done = state_reg[2];

  pciarb_sync u_sync_pg (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .d_in(~power_good_in),
    .q_out(pg_n_s)
  );
  pciarb_sync u_sync_serr (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .d_in(serr_n_in),
    .q_out(serr_s)
  );
  pciarb_sync u_sync_lock (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .d_in(lock_n_in),
    .q_out(lock_s)
  );
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_int
      pciarb_sync u_sync_int (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .d_in(pci_int_n_in[gi]),
        .q_out(int_s[gi])
      );
    end
  endgenerate

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_WAIT: begin
        // Straps settle a few clocks after power good rises
        if (pg_s && pg_d_reg && (wait_reg == `PCIARB_STRAP_WAIT)) begin
          state_next = ST_SAMPLE;
        end
      end
      ST_SAMPLE: state_next = ST_RUN;
      ST_RUN: state_next = ST_RUN;
      default: state_next = ST_WAIT;
    endcase
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_WAIT;
      wait_reg <= 4'h0;
      pg_d_reg <= 1'b0;
      arb_en_reg <= 1'b0;
      flush_mode_reg <= 1'b1;
      cpu_alt_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pg_d_reg <= pg_s;
      if (!pg_s) begin
        wait_reg <= 4'h0;
      end else if (wait_reg != `PCIARB_STRAP_WAIT) begin
        wait_reg <= wait_reg + 4'h1;
      end
      if (state_reg == ST_SAMPLE) begin
        arb_en_reg <= arb_strap_gnt2_n_in;
        flush_mode_reg <= fifth_master_strap_gnt3_n_in | ~arb_strap_gnt2_n_in;
        cpu_alt_reg <= cpu_family_strap_in;
      end
    end
  end

  // ****************************************************
  // Register port
  // ****************************************************
  reg [7:0] ctrl_reg;
  reg [15:0] route_reg;
  reg nmi_reg;
  reg lock_reg;
  reg lock_d_reg;
  reg [`PCIARB_NREQ-1:0] gnt_reg;
  wire wr_ctrl = reg_wr_in && (reg_addr_in == `PCIARB_OFF_CTRL);
  wire nmi_clr = wr_ctrl && reg_wdata_in[`PCIARB_CTRL_NMI_CLR];

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_reg <= `PCIARB_CTRL_RESET;
      route_reg <= `PCIARB_ROUTE_RESET;
      reg_rdata_out <= 16'h0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= {4'h0, reg_wdata_in[3:0]};
      end
      if (reg_wr_in && (reg_addr_in == `PCIARB_OFF_ROUTE)) begin
        route_reg <= reg_wdata_in;
      end
      reg_rdata_out <= 16'h0000;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `PCIARB_OFF_CTRL: reg_rdata_out <= {8'h00, ctrl_reg};
          `PCIARB_OFF_STATUS: reg_rdata_out <= {9'h000, strap_done,
            ~req4_buffer_flush_ack_n_in & flush_mode_reg, lock_reg, nmi_reg,
            cpu_alt_reg, flush_mode_reg, arb_en_reg};
          `PCIARB_OFF_ROUTE: reg_rdata_out <= route_reg;
          `PCIARB_OFF_GRANT: reg_rdata_out <= {9'h000, gnt_reg};
          default: reg_rdata_out <= 16'h0000;
        endcase
      end
    end
  end

  // ****************************************************
  // Error, interrupt routing, lock
  // ****************************************************
  integer k;
  reg [15:0] irq_next;
  always @* begin
    irq_next = 16'h0000;
    for (k = 0; k < 4; k = k + 1) begin
      // Zero route means unrouted; IRQ 0 is the timer and never shared
      if (!int_s[k] && (route_reg[k*4 +: 4] != 4'h0)) begin
        irq_next[route_reg[k*4 +: 4]] = 1'b1;
      end
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nmi_reg <= 1'b0;
      lock_reg <= 1'b0;
      lock_d_reg <= 1'b0;
      nmi_out <= 1'b0;
      pic_irq_out <= 16'h0000;
      lock_active_out <= 1'b0;
      cpu_alt_mode_out <= 1'b0;
    end else begin
      // New error wins over a clear in the same cycle
      if (!serr_s && ctrl_reg[`PCIARB_CTRL_SERR_EN]) begin
        nmi_reg <= 1'b1;
      end else if (nmi_clr) begin
        nmi_reg <= 1'b0;
      end
      nmi_out <= nmi_reg;
      pic_irq_out <= irq_next;
      // Lock stays while line held; released only when idle after the operation
      lock_d_reg <= ~lock_s;
      if (!lock_s) begin
        lock_reg <= 1'b1;
      end else if (lock_d_reg == 1'b0) begin
        lock_reg <= 1'b0;
      end
      lock_active_out <= lock_reg;
      cpu_alt_mode_out <= cpu_alt_reg;
    end
  end

  // ****************************************************
  // Arbiter: 0 host, 1..5 masters 0..4, rotating priority
  // ****************************************************
  reg [`PCIARB_NREQ-1:0] req_vec;
  reg [`PCIARB_NREQ-1:0] gnt_next;
  reg [2:0] last_reg;
  reg [2:0] idx;
  reg [3:0] rot_sum;
  reg found;
  integer j;
  always @* begin
    req_vec[0] = ~host_bridge_request_n_in;
    req_vec[1] = ~isa_gnt_req0_n_in;
    req_vec[2] = ~ide_gnt_req1_n_in;
    req_vec[3] = ~req2_n_in;
    req_vec[4] = ~req3_n_in;
    req_vec[5] = ~req4_buffer_flush_ack_n_in & ~flush_mode_reg;
    req_vec[6] = 1'b0;
    gnt_next = {`PCIARB_NREQ{1'b0}};
    found = 1'b0;
    idx = 3'd0;
    rot_sum = 4'h0;
    // Keep the current grant while requested or while the bus is locked
    if ((|(gnt_reg & req_vec)) || (lock_reg && (|gnt_reg))) begin
      gnt_next = gnt_reg;
    end else begin
      for (j = 1; j <= 6; j = j + 1) begin
        // Four bits so the wrap past the last requester is not lost
        rot_sum = {1'b0, last_reg} + {1'b0, j[2:0]};
        idx = (rot_sum > 4'h5) ? rot_sum[2:0] - 3'h6 : rot_sum[2:0];
        if (!found && req_vec[idx]) begin
          gnt_next[idx] = 1'b1;
          found = 1'b1;
        end
      end
    end
    if (!arb_en_reg || !strap_done) begin
      gnt_next = {`PCIARB_NREQ{1'b0}};
    end
  end

  integer m;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gnt_reg <= {`PCIARB_NREQ{1'b0}};
      last_reg <= 3'd0;
    end else begin
      gnt_reg <= gnt_next;
      for (m = 0; m < 6; m = m + 1) begin
        if (gnt_next[m]) begin
          last_reg <= m[2:0];
        end
      end
    end
  end

  // ****************************************************
  // Pin drive
  // ****************************************************
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      isa_req_gnt0_n_out <= 1'b1;
      ide_req_gnt1_n_out <= 1'b1;
      arb_strap_gnt2_n_out <= 1'b1;
      arb_strap_gnt2_oe_out <= 1'b0;
      fifth_master_strap_gnt3_n_out <= 1'b1;
      fifth_master_strap_gnt3_oe_out <= 1'b0;
      gnt4_buffer_flush_request_n_out <= 1'b1;
      host_bridge_grant_n_out <= 1'b1;
      host_bridge_grant_oe_out <= 1'b0;
    end else begin
      if (arb_en_reg) begin
        isa_req_gnt0_n_out <= ~gnt_next[1];
        ide_req_gnt1_n_out <= ~gnt_next[2];
      end else begin
        isa_req_gnt0_n_out <= ~(strap_done & ctrl_reg[`PCIARB_CTRL_ISA_REQ]);
        ide_req_gnt1_n_out <= ~(strap_done & ctrl_reg[`PCIARB_CTRL_IDE_REQ]);
      end
      // Strap pins float until capture so the resistors are read clean
      arb_strap_gnt2_oe_out <= strap_done & arb_en_reg;
      arb_strap_gnt2_n_out <= ~gnt_next[3];
      fifth_master_strap_gnt3_oe_out <= strap_done & arb_en_reg;
      fifth_master_strap_gnt3_n_out <= ~gnt_next[4];
      host_bridge_grant_oe_out <= strap_done & arb_en_reg;
      host_bridge_grant_n_out <= ~gnt_next[0];
      if (flush_mode_reg) begin
        gnt4_buffer_flush_request_n_out <=
          ~(strap_done & ctrl_reg[`PCIARB_CTRL_FLUSH_REQ]);
      end else begin
        gnt4_buffer_flush_request_n_out <= ~gnt_next[5];
      end
    end
  end
endmodule

//--- test/pciarb_partner.sv
// Purpose: far-side model: external masters, host bridge, external arbiter
// Assumes: pins active low, all changes right after a rising edge
// Notes: masters drop their request once granted, then ask again
module pciarb_partner (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Mode and stimulus
  input wire arb_on_in,
  input wire flush_in,
  input wire slow_in,
  input wire [5:0] want_in,
  // Pins: bit0 host, bits 1..5 pairs 0..4
  input wire [5:0] gnt_n_in,
  output reg [5:0] req_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [3:0] ack_dly;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_n_out <= 6'h3f;
      ack_dly <= 4'hf;
    end else begin
      ack_dly <= {ack_dly[2:0], gnt_n_in[5]};
      req_n_out <= ~(want_in & gnt_n_in) | {6{!arb_on_in}};
      if (!arb_on_in) begin
        // External arbiter favours the ISA side when both ask
        req_n_out[1] <= gnt_n_in[1];
        req_n_out[2] <= gnt_n_in[2] | !gnt_n_in[1];
      end
      if (flush_in)
        req_n_out[5] <= slow_in ? ack_dly[3] : ack_dly[0];
    end
  end
endmodule

//--- test/pciarb_chk.sv
// Purpose: port-level checks for the arbiter and strap block
// Assumes: pins active low, one clock domain
// Notes: grant checks apply only while the grant pins are driven
module pciarb_chk (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Watched ports
  input wire isa_req_gnt0_n_out,
  input wire isa_gnt_req0_n_in,
  input wire ide_req_gnt1_n_out,
  input wire ide_gnt_req1_n_in,
  input wire arb_strap_gnt2_n_out,
  input wire arb_strap_gnt2_oe_out,
  input wire req2_n_in,
  input wire fifth_master_strap_gnt3_n_out,
  input wire fifth_master_strap_gnt3_oe_out,
  input wire req3_n_in,
  input wire req4_buffer_flush_ack_n_in,
  input wire host_bridge_grant_n_out,
  input wire host_bridge_grant_oe_out,
  input wire host_bridge_request_n_in,
  input wire serr_n_in,
  input wire lock_n_in,
  input wire nmi_out,
  input wire lock_active_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire on = arb_strap_gnt2_oe_out;
  wire [4:0] gn = {isa_req_gnt0_n_out, ide_req_gnt1_n_out, arb_strap_gnt2_n_out,
    fifth_master_strap_gnt3_n_out, host_bridge_grant_n_out};
  wire idle = &{gn, isa_gnt_req0_n_in, ide_gnt_req1_n_in, req3_n_in,
    req4_buffer_flush_ack_n_in, host_bridge_request_n_in};
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // **********
  // Assertions
  // **********
  a_one_grant:
    assert property (on |-> $onehot0(~gn)) else $error("more than one grant low");
  a_req2_answer:
    assert property (on && idle && !req2_n_in |=> !arb_strap_gnt2_n_out)
    else $error("lone request 2 not granted");
  a_gnt2_release:
    assert property (on && !arb_strap_gnt2_n_out && req2_n_in && !lock_active_out
      |=> arb_strap_gnt2_n_out) else $error("grant 2 held after request dropped");
  a_oe_together:
    assert property (on == fifth_master_strap_gnt3_oe_out && on == host_bridge_grant_oe_out)
    else $error("shared grant pins not enabled together");
  a_strap_quiet:
    assert property ($rose(rst_n_in) |-> (!(on || host_bridge_grant_oe_out)) [*5])
    else $error("strap pin driven too early");
  a_nmi_cause:
    assert property ($rose(nmi_out) |-> !($past(serr_n_in, 2) && $past(serr_n_in, 3)
      && $past(serr_n_in, 4))) else $error("nmi rose without system error");
  a_lock_set:
    assert property ((!lock_n_in) [*4] |=> lock_active_out) else $error("lock not taken");
  a_lock_free:
    assert property (lock_n_in [*5] |=> !lock_active_out) else $error("lock not freed");
  c_grant2: cover property (!arb_strap_gnt2_n_out);
  c_nmi: cover property ($rose(nmi_out));
  c_lock: cover property ($rose(lock_active_out));
endmodule

bind pciarb_top pciarb_chk pciarb_chk_i (.clk_in, .rst_n_in, .isa_req_gnt0_n_out,
  .isa_gnt_req0_n_in, .ide_req_gnt1_n_out, .ide_gnt_req1_n_in, .arb_strap_gnt2_n_out,
  .arb_strap_gnt2_oe_out, .req2_n_in, .fifth_master_strap_gnt3_n_out,
  .fifth_master_strap_gnt3_oe_out, .req3_n_in, .req4_buffer_flush_ack_n_in,
  .host_bridge_grant_n_out, .host_bridge_grant_oe_out, .host_bridge_request_n_in,
  .serr_n_in, .lock_n_in, .nmi_out, .lock_active_out);

//--- test/pci_arbiter_pin_config_test.sv
// Purpose: self-checking bench for the PCI arbiter and strap block
// Assumes: straps are weak pulls seen whenever a shared pin is undriven
// Notes: three power-ups: arbiter with pair 4, arbiter with flush, no arbiter
module pci_arbiter_pin_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  reg clk_in = 1'h0;
  reg rst_n_in = 1'h0;
  reg power_good_in = 1'h0;
  reg [3:0] reg_addr_in = 4'h0;
  reg [15:0] reg_wdata_in = 16'h0000;
  reg reg_wr_in = 1'h0;
  reg reg_rd_in = 1'h0;
  reg serr_n_in = 1'h1;
  reg lock_n_in = 1'h1;
  reg [3:0] pci_int_n_in = 4'hf;
  reg s_arb = 1'h1, s_fifth = 1'h0, s_cpu = 1'h0, slow = 1'h0;
  reg [5:0] want = 6'h00;
  reg [5:0] seen;
  reg [15:0] v;
  reg [31:0] seed = 32'hc48a;
  integer fail_count = 0, samples_checked = 0, p, i, n;
  wire [15:0] reg_rdata_out, pic_irq_out;
  wire isa_req_gnt0_n_out, ide_req_gnt1_n_out, arb_strap_gnt2_n_out, arb_strap_gnt2_oe_out;
  wire fifth_master_strap_gnt3_n_out, fifth_master_strap_gnt3_oe_out;
  wire gnt4_buffer_flush_request_n_out, host_bridge_grant_n_out, host_bridge_grant_oe_out;
  wire nmi_out, lock_active_out, cpu_alt_mode_out;
  wire [5:0] req_n;
  // Shared pins: driven level wins over the strap pull
  wire arb_strap_gnt2_n_in = arb_strap_gnt2_oe_out ? arb_strap_gnt2_n_out : s_arb;
  wire fifth_master_strap_gnt3_n_in =
    fifth_master_strap_gnt3_oe_out ? fifth_master_strap_gnt3_n_out : s_fifth;
  wire cpu_family_strap_in = host_bridge_grant_oe_out ? host_bridge_grant_n_out : s_cpu;
  wire [5:0] gv = {gnt4_buffer_flush_request_n_out, fifth_master_strap_gnt3_n_in,
    arb_strap_gnt2_n_in, ide_req_gnt1_n_out, isa_req_gnt0_n_out, cpu_family_strap_in};
  pciarb_top pciarb_top_i (.clk_in, .rst_n_in, .power_good_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .isa_req_gnt0_n_out,
    .isa_gnt_req0_n_in(req_n[1]), .ide_req_gnt1_n_out, .ide_gnt_req1_n_in(req_n[2]),
    .arb_strap_gnt2_n_in, .arb_strap_gnt2_n_out, .arb_strap_gnt2_oe_out, .req2_n_in(req_n[3]),
    .fifth_master_strap_gnt3_n_in, .fifth_master_strap_gnt3_n_out,
    .fifth_master_strap_gnt3_oe_out, .req3_n_in(req_n[4]), .gnt4_buffer_flush_request_n_out,
    .req4_buffer_flush_ack_n_in(req_n[5]), .cpu_family_strap_in, .host_bridge_grant_n_out,
    .host_bridge_grant_oe_out, .host_bridge_request_n_in(req_n[0]), .serr_n_in,
    .pci_int_n_in, .lock_n_in, .nmi_out, .pic_irq_out, .lock_active_out, .cpu_alt_mode_out);
  pciarb_partner pciarb_partner_i (.clk_in, .rst_n_in, .arb_on_in(s_arb),
    .flush_in(!s_arb || s_fifth), .slow_in(slow), .want_in(want), .gnt_n_in(gv),
    .req_n_out(req_n));
  initial forever #5 clk_in = ~clk_in;
  // **********
  // Helpers
  // **********
  function [31:0] xs(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  function [15:0] st_exp(input a, input f, input c);
    st_exp = {9'h000, 1'h1, 3'h0, c, !a | f, a};
  endfunction
  function [15:0] irq_exp(input [15:0] rt, input [3:0] in_n);
    integer k;
    begin
      irq_exp = 16'h0000;
      for (k = 0; k < 4; k = k + 1)
        if (rt[4*k+:4] != 4'h0 && !in_n[k]) irq_exp[rt[4*k+:4]] = 1'h1;
    end
  endfunction
  task check(input string nm, input [15:0] got, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("Error %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    begin
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'h1;
      @(posedge clk_in);
      reg_wr_in <= 1'h0;
      @(posedge clk_in);
    end
  endtask
  task rd(input [3:0] a, output [15:0] d);
    begin
      reg_addr_in <= a;
      reg_rd_in <= 1'h1;
      @(posedge clk_in);
      reg_rd_in <= 1'h0;
      @(posedge clk_in);
      d = reg_rdata_out;
    end
  endtask
  task power_up(input a, input f);
    begin
      seed = xs(seed);
      rst_n_in <= 1'h0;
      power_good_in <= 1'h0;
      s_arb <= a;
      s_fifth <= f;
      s_cpu <= seed[0];
      slow <= f;
      repeat (4) @(posedge clk_in);
      rst_n_in <= 1'h1;
      repeat (2) @(posedge clk_in);
      power_good_in <= 1'h1;
      v = 16'h0000;
      for (n = 0; n < 40 && !v[6]; n = n + 1) rd(4'h1, v);
      repeat (2) @(posedge clk_in);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count = fail_count + 1;
    give_verdict;
  end
  // **********
  // Tests
  // **********
  initial begin
    for (p = 0; p < 3; p = p + 1) begin
      power_up(p != 2, p == 1);
      rd(4'h1, v);
      check("status", v & 16'h007f, st_exp(s_arb, s_fifth, s_cpu));
      check("cpu mode", {15'h0000, cpu_alt_mode_out}, {15'h0000, s_cpu});
      for (i = 0; i < 12 && s_arb; i = i + 1) begin
        seed = xs(seed);
        // Lone requests first (request 2, then host bridge), then random mixes
        want <= (i == 0) ? 6'h08 : (i == 1) ? 6'h01 : seed[5:0] & {!s_fifth, 5'h1f};
        seen = 6'h00;
        repeat (24) begin
          @(posedge clk_in);
          seen = seen | ~gv;
        end
        check("served", {10'h000, seen & want}, {10'h000, want});
        want <= 6'h00;
        repeat (4) @(posedge clk_in);
        rd(4'h3, v);
        check("grant reg", v, 16'h0000);
      end
      wr(4'h0, 16'h0002);
      repeat (3) @(posedge clk_in);
      check("gnt4 pin", {15'h0000, gnt4_buffer_flush_request_n_out},
        {15'h0000, s_arb & ~s_fifth});
      repeat (8) @(posedge clk_in);
      rd(4'h1, v);
      if (!s_arb || s_fifth) check("flush ack", v & 16'h0020, 16'h0020);
      wr(4'h0, 16'h000c);
      repeat (3) @(posedge clk_in);
      check("isa ide req", {14'h0000, isa_req_gnt0_n_out, ide_req_gnt1_n_out},
        {14'h0000, s_arb, s_arb});
      for (n = 1; n >= 0; n = n - 1) begin
        wr(4'h0, n[15:0]);
        serr_n_in <= 1'h0;
        repeat (2) @(posedge clk_in);
        serr_n_in <= 1'h1;
        repeat (5) @(posedge clk_in);
        check("nmi", {15'h0000, nmi_out}, n[15:0]);
        wr(4'h0, 16'h0010);
      end
      seed = xs(seed);
      wr(4'h2, seed[15:0]);
      pci_int_n_in <= seed[19:16];
      repeat (5) @(posedge clk_in);
      check("irq", pic_irq_out, irq_exp(seed[15:0], seed[19:16]));
      pci_int_n_in <= 4'hf;
      lock_n_in <= 1'h0;
      repeat (6) @(posedge clk_in);
      rd(4'h1, v);
      check("locked", v & 16'h0010, 16'h0010);
      check("lock out", {15'h0000, lock_active_out}, 16'h0001);
      lock_n_in <= 1'h1;
      rd(4'h9, v);
      check("unmapped", v, 16'h0000);
      $display("power-up %0d done", p);
    end
    give_verdict;
  end
endmodule
